// ### shared/shp_pkg.sv
/*
  Shared constants and types for the serial host port: pin sync reset
  values, serial clock timing, I2C own-address base, the engine state
  encoding and the packed carriers for configuration and engine state.
  Assumes a single 10 MHz core clock; no other files are needed.
*/
package shp_pkg;

  localparam int WORD_W = 8;
  localparam int NPIN = 5;

  // Sync index of each shared pin
  localparam int PIN_SCK = 4;
  localparam int PIN_MISO = 3;
  localparam int PIN_MOSI = 2;
  localparam int PIN_SS = 1;
  localparam int PIN_WREQ = 0;
  localparam logic [4:0] SYNC_RST = 5'h1F;

  // Core clock and generated serial clock half period
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS = 500;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS < 1 ? 1 :
                                (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int DIV_W = 8;

  // Own slave address; value arbitrary, straps replace bits 2 and 0
  localparam logic [6:0] I2C_ADDR_BASE = 7'h2A;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_SPI      = 4'h1,
    ST_SA_ADR   = 4'h2,
    ST_SA_ACK   = 4'h3,
    ST_SA_RX    = 4'h4,
    ST_SA_TX    = 4'h5,
    ST_SA_TACK  = 4'h6,
    ST_SA_WAIT  = 4'h7,
    ST_MA_START = 4'h8,
    ST_MA_BIT   = 4'h9,
    ST_MA_ACK   = 4'hA,
    ST_MA_STOP  = 4'hB
  } shp_state_t;

  typedef struct packed {
    logic i2c;
    logic master;
    logic cpol;
    logic cpha;
  } shp_cfg_t;

  localparam shp_cfg_t CFG_RST = 4'h0;

  typedef struct packed {
    shp_state_t st;
    logic [3:0] bitn;
    logic [7:0] rxs;
    logic [7:0] txs;
    logic dout;
    logic sck;
    logic scl_low;
    logic sda_low;
    logic [1:0] ph;
    logic rw;
    logic done;
    logic skip;
    logic push;
    logic pop;
    logic nack;
  } shp_eng_t;

  localparam shp_eng_t ENG_RST = '{st: ST_IDLE, default: '0};

endpackage

// ### src/shp_port.sv
/*
  Serial host port: five shared pins run as SPI master/slave or I2C
  master/slave. Transmit words arrive on a one-word holding register,
  received words leave through a two-entry buffer. Two-way pins are
  split into input, output and output enable; the bench resolves them.
  Assumes all pin inputs are asynchronous to I_CLK and that the
  configuration and request-enable inputs come from core logic.
*/
// Functional notes
// (R1) Five shared pins switch between SPI and I2C roles by mode.
// (R2) SPI master drives serial clock from divider; slave takes it as input.
// (R3) SPI slave ignores serial clock while slave select is high.
// (R4) Shift on one clock edge, sample on the opposite, per polarity/phase.
// (R5) Master drives MOSI, reads MISO; slave reads MOSI, drives MISO.
// (R6) SPI slave keeps MISO released while slave select is high.
// (R7) Slave select is active low; slave transfers only while it is low.
// (R8) Far side keeps slave select high while we are SPI master.
// (R9) Slave select low during SPI master mode sets a bus error flag.
// (R10) I2C slave only reads SCL; I2C master drives it open drain.
// (R11) I2C reads SDA when receiving, pulls it low only when sending.
// (R12) SDA changes only while SCL is low, except start and stop.
// (R13) Start is SDA falling while SCL is high.
// (R14) Stop is SDA rising while SCL high; free bus leaves SDA high.
// (R15) Two strap inputs form part of own I2C slave address.
// (R16) Slave drives word request low when ready, high at first clock.
// (R17) Master waits for word request low before each word.
// (R18) Word request released in reset and when request enables are zero.
// (R19) All port pins released during hardware and port resets.
// (R20) Mode and role come from config bits taken only while idle.
module shp_port #(
  parameter int HALF_CYC = shp_pkg::SCK_HALF_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PORT_RST,
  input wire shp_pkg::shp_cfg_t I_CFG,
  input wire logic [1:0] I_REQ_EN,
  input wire logic I_ERR_CLR,
  input wire logic I_TX_VALID,
  input wire logic [7:0] I_TX_DATA,
  output logic O_TX_READY,
  output logic O_RX_VALID,
  output logic [7:0] O_RX_DATA,
  input wire logic I_RX_READY,
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE,
  input wire logic I_SS_N,
  input wire logic I_WREQ_N,
  output logic O_WREQ_N,
  output logic O_WREQ_OE,
  output logic O_BUS_ERR,
  output logic O_OVRUN
);

  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic sck_p_q;
  logic sda_p_q;
  shp_pkg::shp_cfg_t cfg_q;
  shp_pkg::shp_eng_t e_q;
  logic [shp_pkg::DIV_W-1:0] div_q;
  logic tick_q;
  logic [7:0] tx_q;
  logic tx_full_q;
  logic [7:0] rd_q [2];
  logic [1:0] rv_q;
  logic wbusy_q;

  logic sck_s, sda_s, mosi_s, ss_n_s, wreq_n_s;
  logic sck_r, sck_f, i2c_start, i2c_stop;
  logic m_edge, lead, trail, smp, shf, din;
  logic rx_room, go, first, run_div, sl_i2c;
  logic [6:0] own_addr;
  logic [7:0] tx_word;

  // Two-stage sync of all pin inputs
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sync1_q <= shp_pkg::SYNC_RST;
      sync2_q <= shp_pkg::SYNC_RST;
      sck_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {I_SCK, I_MISO, I_MOSI, I_SS_N, I_WREQ_N};
      sync2_q <= sync1_q;
      sck_p_q <= sck_s;
      sda_p_q <= sda_s;
    end
  end

  assign sck_s = sync2_q[shp_pkg::PIN_SCK];
  assign sda_s = sync2_q[shp_pkg::PIN_MISO];
  assign mosi_s = sync2_q[shp_pkg::PIN_MOSI];
  assign ss_n_s = sync2_q[shp_pkg::PIN_SS];
  assign wreq_n_s = sync2_q[shp_pkg::PIN_WREQ];

  assign sck_r = sck_s & ~sck_p_q;
  assign sck_f = ~sck_s & sck_p_q;
  assign i2c_start = sck_s & sck_p_q & sda_p_q & ~sda_s;   // [R13]
  assign i2c_stop = sck_s & sck_p_q & ~sda_p_q & sda_s;    // [R14]
  assign sl_i2c = cfg_q.i2c & ~cfg_q.master;

  // Master clock edges; slave edges only count with select low
  assign m_edge = tick_q & (~e_q.done | (e_q.sck != cfg_q.cpol));
  always_comb begin
    if (cfg_q.master) begin
      lead = m_edge & (e_q.sck == cfg_q.cpol);
      trail = m_edge & (e_q.sck != cfg_q.cpol);
    end else begin
      lead = (cfg_q.cpol ? sck_f : sck_r) & ~ss_n_s;   // [R3] [R7]
      trail = (cfg_q.cpol ? sck_r : sck_f) & ~ss_n_s;  // [R3] [R7]
    end
  end
  assign smp = cfg_q.cpha ? trail : lead;  // [R4]
  assign shf = cfg_q.cpha ? lead : trail;  // [R4]
  assign din = cfg_q.master ? sda_s : mosi_s;  // [R5]

  assign own_addr = {shp_pkg::I2C_ADDR_BASE[6:3], ss_n_s,
                     shp_pkg::I2C_ADDR_BASE[1], mosi_s};  // [R15]
  assign rx_room = ~rv_q[1] & ~e_q.push;
  assign tx_word = tx_full_q ? tx_q : 8'h00;
  assign go = tx_full_q & rx_room & ~e_q.pop
              & ((I_REQ_EN == 2'h0) | ~wreq_n_s);  // [R17]

  // Mode taken only between transfers
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_q <= shp_pkg::CFG_RST;
    end else if (e_q.st == shp_pkg::ST_IDLE) begin
      cfg_q <= I_CFG;  // [R20]
    end
  end

  // Serial clock divider, one-cycle tick per half period
  assign run_div = cfg_q.master & (e_q.st != shp_pkg::ST_IDLE);
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (!run_div || I_PORT_RST) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == shp_pkg::DIV_W'(HALF_CYC - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;  // [R2]
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Transfer engine
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      e_q <= shp_pkg::ENG_RST;
    end else if (I_PORT_RST) begin
      e_q <= shp_pkg::ENG_RST;
    end else begin
      e_q.push <= 1'b0;
      e_q.pop <= 1'b0;
      e_q.nack <= 1'b0;
      if (sl_i2c && e_q.st != shp_pkg::ST_IDLE
          && (i2c_start || i2c_stop)) begin
        e_q.sda_low <= 1'b0;
        e_q.bitn <= 4'h0;
        e_q.st <= i2c_start ? shp_pkg::ST_SA_ADR
                            : shp_pkg::ST_IDLE;  // [R13] [R14]
      end else begin
        case (e_q.st)
          shp_pkg::ST_IDLE: begin
            e_q.sda_low <= 1'b0;
            e_q.scl_low <= 1'b0;
            e_q.bitn <= 4'h0;
            e_q.done <= 1'b0;
            e_q.skip <= 1'b0;
            if (cfg_q.i2c) begin
              if (!cfg_q.master && i2c_start) begin
                e_q.st <= shp_pkg::ST_SA_ADR;
              end else if (cfg_q.master && go) begin
                e_q.sda_low <= 1'b1;  // [R13]
                e_q.st <= shp_pkg::ST_MA_START;
              end
            end else if (!cfg_q.master ? !ss_n_s : (go && ss_n_s)) begin
              e_q.st <= shp_pkg::ST_SPI;
              e_q.sck <= cfg_q.cpol;
              e_q.txs <= cfg_q.cpha ? tx_word : {tx_word[6:0], 1'b0};
              e_q.dout <= cfg_q.cpha ? e_q.dout : tx_word[7];
              e_q.pop <= tx_full_q;
            end
          end
          shp_pkg::ST_SPI: begin
            if (!cfg_q.master && ss_n_s) begin
              e_q.st <= shp_pkg::ST_IDLE;  // [R6] [R7]
            end else begin
              if (cfg_q.master && m_edge) begin
                e_q.sck <= ~e_q.sck;  // [R2]
              end
              if (smp) begin
                e_q.rxs <= {e_q.rxs[6:0], din};  // [R4] [R5]
                e_q.bitn <= e_q.bitn + 4'h1;
                if (e_q.bitn == 4'h7) begin
                  e_q.push <= 1'b1;
                  e_q.bitn <= 4'h0;
                  e_q.done <= cfg_q.master;
                  if (!cfg_q.master) begin
                    e_q.txs <= cfg_q.cpha ? tx_word
                                          : {tx_word[6:0], 1'b0};
                    e_q.dout <= cfg_q.cpha ? e_q.dout : tx_word[7];
                    e_q.pop <= tx_full_q;
                    e_q.skip <= ~cfg_q.cpha;
                  end
                end
              end
              if (shf) begin
                if (e_q.skip) begin
                  e_q.skip <= 1'b0;
                end else begin
                  e_q.dout <= e_q.txs[7];  // [R4]
                  e_q.txs <= {e_q.txs[6:0], 1'b0};
                end
              end
              if (cfg_q.master && e_q.done && e_q.sck == cfg_q.cpol) begin
                e_q.st <= shp_pkg::ST_IDLE;  // [R17]
              end
            end
          end
          shp_pkg::ST_SA_ADR: begin
            if (sck_r) begin
              e_q.rxs <= {e_q.rxs[6:0], sda_s};  // [R11]
              e_q.bitn <= e_q.bitn + 4'h1;
            end
            if (sck_f && e_q.bitn == 4'h8) begin
              e_q.bitn <= 4'h0;
              if (e_q.rxs[7:1] == own_addr) begin  // [R15]
                e_q.sda_low <= 1'b1;
                e_q.rw <= e_q.rxs[0];
                e_q.st <= shp_pkg::ST_SA_ACK;
              end else begin
                e_q.st <= shp_pkg::ST_SA_WAIT;
              end
            end
          end
          shp_pkg::ST_SA_ACK: begin
            if (sck_f) begin  // [R12]
              e_q.sda_low <= 1'b0;
              e_q.bitn <= 4'h0;
              e_q.st <= shp_pkg::ST_SA_RX;
              if (e_q.rw) begin
                e_q.sda_low <= ~tx_word[7];  // [R11]
                e_q.txs <= {tx_word[6:0], 1'b0};
                e_q.pop <= tx_full_q;
                e_q.bitn <= 4'h1;
                e_q.st <= shp_pkg::ST_SA_TX;
              end
            end
          end
          shp_pkg::ST_SA_RX: begin
            if (sck_r) begin
              e_q.rxs <= {e_q.rxs[6:0], sda_s};
              e_q.bitn <= e_q.bitn + 4'h1;
            end
            if (sck_f && e_q.bitn == 4'h8) begin
              e_q.push <= 1'b1;
              e_q.bitn <= 4'h0;
              e_q.sda_low <= rx_room;
              e_q.st <= shp_pkg::ST_SA_ACK;
            end
          end
          shp_pkg::ST_SA_TX: begin
            if (sck_f) begin  // [R12]
              if (e_q.bitn == 4'h8) begin
                e_q.sda_low <= 1'b0;
                e_q.st <= shp_pkg::ST_SA_TACK;
              end else begin
                e_q.sda_low <= ~e_q.txs[7];
                e_q.txs <= {e_q.txs[6:0], 1'b0};
                e_q.bitn <= e_q.bitn + 4'h1;
              end
            end
          end
          shp_pkg::ST_SA_TACK: begin
            if (sck_r) begin
              e_q.st <= sda_s ? shp_pkg::ST_SA_WAIT : shp_pkg::ST_SA_ACK;
            end
          end
          shp_pkg::ST_SA_WAIT: begin
            e_q.sda_low <= 1'b0;
          end
          shp_pkg::ST_MA_START: begin
            if (tick_q) begin
              e_q.scl_low <= 1'b1;  // [R10]
              e_q.txs <= tx_q;
              e_q.pop <= 1'b1;
              e_q.bitn <= 4'h0;
              e_q.ph <= 2'h0;
              e_q.st <= shp_pkg::ST_MA_BIT;
            end
          end
          shp_pkg::ST_MA_BIT: begin
            if (tick_q) begin
              case (e_q.ph)
                2'h0: begin  // [R12]
                  e_q.ph <= 2'h1;
                  if (e_q.bitn == 4'h8) begin
                    e_q.sda_low <= 1'b0;
                    e_q.st <= shp_pkg::ST_MA_ACK;
                  end else begin
                    e_q.sda_low <= ~e_q.txs[7];  // [R11]
                    e_q.txs <= {e_q.txs[6:0], 1'b0};
                    e_q.bitn <= e_q.bitn + 4'h1;
                  end
                end
                2'h1: begin
                  e_q.scl_low <= 1'b0;
                  e_q.ph <= 2'h2;
                end
                default: begin
                  if (sck_s) begin
                    e_q.scl_low <= 1'b1;
                    e_q.ph <= 2'h0;
                  end
                end
              endcase
            end
          end
          shp_pkg::ST_MA_ACK: begin
            if (tick_q) begin
              if (e_q.ph == 2'h1) begin
                e_q.scl_low <= 1'b0;
                e_q.ph <= 2'h2;
              end else if (sck_s) begin
                e_q.scl_low <= 1'b1;
                e_q.ph <= 2'h0;
                e_q.nack <= sda_s;
                e_q.st <= shp_pkg::ST_MA_STOP;
                if (!sda_s && go) begin
                  e_q.txs <= tx_q;
                  e_q.pop <= 1'b1;
                  e_q.bitn <= 4'h0;
                  e_q.st <= shp_pkg::ST_MA_BIT;  // [R17]
                end
              end
            end
          end
          shp_pkg::ST_MA_STOP: begin
            if (tick_q) begin
              case (e_q.ph)
                2'h0: begin
                  e_q.sda_low <= 1'b1;
                  e_q.ph <= 2'h1;
                end
                2'h1: begin
                  e_q.scl_low <= 1'b0;
                  e_q.ph <= 2'h2;
                end
                default: begin
                  if (sck_s) begin
                    e_q.sda_low <= 1'b0;  // [R14]
                    e_q.st <= shp_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
          default: begin
            e_q.st <= shp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Transmit holding register
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_q <= 8'h00;
      tx_full_q <= 1'b0;
      O_TX_READY <= 1'b0;
    end else if (I_PORT_RST || e_q.pop) begin
      tx_full_q <= 1'b0;
      O_TX_READY <= 1'b1;
    end else if (I_TX_VALID && O_TX_READY) begin
      tx_q <= I_TX_DATA;
      tx_full_q <= 1'b1;
      O_TX_READY <= 1'b0;
    end else begin
      // Ready follows an empty holding register, also after reset
      O_TX_READY <= ~tx_full_q;
    end
  end

  // Two-entry receive buffer; entry 0 is the output
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_q[0] <= 8'h00;
      rd_q[1] <= 8'h00;
      rv_q <= 2'h0;
      O_OVRUN <= 1'b0;
    end else if (I_PORT_RST) begin
      rv_q <= 2'h0;
      O_OVRUN <= 1'b0;
    end else begin
      if (rv_q[0] && I_RX_READY) begin
        rd_q[0] <= rv_q[1] ? rd_q[1] : e_q.rxs;
        rv_q[0] <= rv_q[1] | e_q.push;
        rd_q[1] <= e_q.rxs;
        rv_q[1] <= rv_q[1] & e_q.push;
      end else if (e_q.push) begin
        if (!rv_q[0]) begin
          rd_q[0] <= e_q.rxs;
          rv_q[0] <= 1'b1;
        end else if (!rv_q[1]) begin
          rd_q[1] <= e_q.rxs;
          rv_q[1] <= 1'b1;
        end else begin
          O_OVRUN <= 1'b1;
        end
      end else if (I_ERR_CLR) begin
        O_OVRUN <= 1'b0;
      end
    end
  end

  always_comb begin
    O_RX_VALID = rv_q[0];
    O_RX_DATA = rd_q[0];
  end

  // Sticky bus error; a new event beats the clear
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_BUS_ERR <= 1'b0;
    end else if (I_PORT_RST) begin
      O_BUS_ERR <= 1'b0;
    end else if ((~cfg_q.i2c & cfg_q.master & ~ss_n_s) | e_q.nack) begin
      O_BUS_ERR <= 1'b1;  // [R8] [R9]
    end else if (I_ERR_CLR) begin
      O_BUS_ERR <= 1'b0;
    end
  end

  // Word request line in slave role
  assign first = (e_q.st == shp_pkg::ST_SPI && !cfg_q.master && lead)
                 || (sck_r && ((e_q.st == shp_pkg::ST_SA_RX
                                && e_q.bitn == 4'h0)
                               || (e_q.st == shp_pkg::ST_SA_TX
                                   && e_q.bitn == 4'h1)));
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_WREQ_N <= 1'b1;
      O_WREQ_OE <= 1'b0;
      wbusy_q <= 1'b0;
    end else if (I_PORT_RST) begin
      O_WREQ_N <= 1'b1;
      O_WREQ_OE <= 1'b0;  // [R18]
      wbusy_q <= 1'b0;
    end else begin
      O_WREQ_OE <= ~cfg_q.master & (I_REQ_EN != 2'h0);  // [R18]
      if (first && !wbusy_q) begin
        O_WREQ_N <= 1'b1;  // [R16]
        wbusy_q <= 1'b1;
      end else begin
        if (e_q.push || e_q.st == shp_pkg::ST_IDLE) begin
          wbusy_q <= 1'b0;
        end
        if (!wbusy_q && tx_full_q && rx_room) begin
          O_WREQ_N <= 1'b0;  // [R16]
        end
      end
    end
  end

  // Pin drivers per mode; all released in any reset
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_SCK <= 1'b0;
      O_SCK_OE <= 1'b0;
      O_MISO <= 1'b0;
      O_MISO_OE <= 1'b0;
      O_MOSI <= 1'b0;
      O_MOSI_OE <= 1'b0;
    end else if (I_PORT_RST) begin
      O_SCK_OE <= 1'b0;   // [R19]
      O_MISO_OE <= 1'b0;  // [R19]
      O_MOSI_OE <= 1'b0;  // [R19]
    end else if (cfg_q.i2c) begin
      O_SCK <= 1'b0;
      O_SCK_OE <= e_q.scl_low;   // [R1] [R10]
      O_MISO <= 1'b0;
      O_MISO_OE <= e_q.sda_low;  // [R1] [R11]
      O_MOSI_OE <= 1'b0;
    end else begin
      O_SCK <= e_q.sck;
      O_SCK_OE <= cfg_q.master;  // [R1] [R2]
      O_MISO <= e_q.dout;
      O_MISO_OE <= ~cfg_q.master
                   & (e_q.st == shp_pkg::ST_SPI) & ~ss_n_s;  // [R5] [R6]
      O_MOSI <= e_q.dout;
      O_MOSI_OE <= cfg_q.master;  // [R5]
    end
  end

endmodule

// ### verif/shp_port_monitor.sv
/*
  Pin checker for the serial host port, bound to shp_port.
  Assumes the configuration only changes while the port is idle.
*/
module shp_port_monitor #(
  parameter int HALF_CYC = 5
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PORT_RST,
  input wire shp_pkg::shp_cfg_t I_CFG,
  input wire logic [1:0] I_REQ_EN,
  input wire logic I_ERR_CLR,
  input wire logic I_SCK,
  input wire logic I_SS_N,
  input wire logic O_SCK,
  input wire logic O_SCK_OE,
  input wire logic O_MISO_OE,
  input wire logic O_MOSI_OE,
  input wire logic O_WREQ_N,
  input wire logic O_WREQ_OE,
  input wire logic O_BUS_ERR
);
  logic [7:0] gap_q;
  logic spi_m;
  logic spi_s;
  assign spi_m = !I_CFG.i2c && I_CFG.master && !I_PORT_RST;
  assign spi_s = !I_CFG.i2c && !I_CFG.master && !I_PORT_RST;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // Cycles since the serial clock output last moved
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN)
      gap_q <= 8'hFF;
    else if ($changed(O_SCK))
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end
  a_port_rst_off: assert property (
    I_PORT_RST |=> !O_SCK_OE && !O_MISO_OE && !O_MOSI_OE && !O_WREQ_OE)
    else $error("pins driven after port reset");
  a_req_en_off: assert property (
    (I_REQ_EN == 2'h0) [*2] |-> !O_WREQ_OE)
    else $error("word request driven while disabled");
  a_master_ss_err: assert property (
    (spi_m && !I_SS_N) [*3] |-> ##[0:3] O_BUS_ERR)
    else $error("select low in master mode not flagged");
  a_err_sticky: assert property (
    O_BUS_ERR && !I_ERR_CLR && !I_PORT_RST |=> O_BUS_ERR)
    else $error("bus error flag lost");
  a_slave_miso_off: assert property (
    (spi_s && I_SS_N) [*5] |-> !O_MISO_OE)
    else $error("data out driven while deselected");
  a_master_pins: assert property (
    spi_m [*4] |-> O_SCK_OE && O_MOSI_OE && !O_MISO_OE)
    else $error("wrong pin directions as master");
  a_slave_pins: assert property (
    spi_s [*4] |-> !O_SCK_OE && !O_MOSI_OE)
    else $error("clock or data in driven as slave");
  a_sck_gap: assert property (
    $changed(O_SCK) && O_SCK_OE |-> gap_q >= HALF_CYC - 1)
    else $error("serial clock half period too short");
  a_wreq_first_clk: assert property (
    spi_s && !I_CFG.cpol && O_WREQ_OE && !O_WREQ_N && !I_SS_N
      && $rose(I_SCK) |-> ##[1:6] O_WREQ_N)
    else $error("word request kept after first clock");
  a_master_wreq_in: assert property (
    spi_m [*3] |-> !O_WREQ_OE)
    else $error("word request driven as master");
endmodule

bind shp_port shp_port_monitor #(.HALF_CYC(HALF_CYC)) u_mon (
  .I_CLK, .I_RSTN, .I_PORT_RST, .I_CFG, .I_REQ_EN, .I_ERR_CLR, .I_SCK,
  .I_SS_N, .O_SCK, .O_SCK_OE, .O_MISO_OE, .O_MOSI_OE, .O_WREQ_N,
  .O_WREQ_OE, .O_BUS_ERR
);

// ### verif/shp_spi_peer.sv
/*
  SPI slave model facing the port in master mode, clock phase 0.
  Assumes it sees the resolved clock and data lines; echoes each word.
*/
module shp_spi_peer (
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] nxt = 8'h3C;
  logic [7:0] sh = 8'h00;
  logic [7:0] r = 8'h00;
  int n = 0;
  // Sample on rise
  always @(posedge i_sck) begin
    if (n == 0)
      sh = nxt;
    r = {r[6:0], i_mosi};
    n = n + 1;
    if (n == 8) begin
      n = 0;
      nxt = r;
    end
  end
  // Shift on fall
  always @(negedge i_sck)
    sh = {sh[6:0], ~sh[0]};
  assign o_miso = (n == 0) ? nxt[7] : sh[7];
endmodule

// ### verif/tb.sv
/*
  Self-checking bench for the serial host port in SPI roles.
  Assumes the SPI slave model and the bound pin checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, prst, errclr, txv, rxr, sck_b, mosi_b, ss_n, wreq_b;
  logic txrdy, rxv, sck, sck_oe, miso, miso_oe, mosi, mosi_oe;
  logic wreq, wreq_oe, berr, ovr, pmiso, sck_w, miso_w, mosi_w;
  logic [1:0] req_en;
  logic [7:0] txd, rxd, last, d, mi, mo;
  shp_pkg::shp_cfg_t cfg;
  logic [7:0] q[$];
  int n_errors, compares, seed, k;
  assign sck_w = sck_oe ? sck : sck_b;
  assign miso_w = miso_oe ? miso : pmiso;
  assign mosi_w = mosi_oe ? mosi : mosi_b;
  shp_port #(.HALF_CYC(4)) dut (
    .I_CLK(clk), .I_RSTN(rstn), .I_PORT_RST(prst), .I_CFG(cfg),
    .I_REQ_EN(req_en), .I_ERR_CLR(errclr), .I_TX_VALID(txv),
    .I_TX_DATA(txd), .O_TX_READY(txrdy), .O_RX_VALID(rxv),
    .O_RX_DATA(rxd), .I_RX_READY(rxr), .I_SCK(sck_w), .O_SCK(sck),
    .O_SCK_OE(sck_oe), .I_MISO(miso_w), .O_MISO(miso),
    .O_MISO_OE(miso_oe), .I_MOSI(mosi_w), .O_MOSI(mosi),
    .O_MOSI_OE(mosi_oe), .I_SS_N(ss_n), .I_WREQ_N(wreq_b),
    .O_WREQ_N(wreq), .O_WREQ_OE(wreq_oe), .O_BUS_ERR(berr),
    .O_OVRUN(ovr)
  );
  shp_spi_peer peer (.i_sck(sck_w), .i_mosi(mosi_w), .o_miso(pmiso));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] v);
    txd = v;
    txv = 1;
    for (k = 0; k < 500 && txrdy !== 1'b1; k++)
      step(1);
    step(1);
  endtask
  // Master word: the peer answers with the word it got before
  task automatic mput;
    d = 8'($random(seed));
    q.push_back(last);
    last = d;
    send(d);
  endtask
  task automatic drain;
    for (k = 0; k < 3000 && q.size() != 0; k++)
      step(1);
    chk(8'(q.size()), 8'h00);
  endtask
  // Bench as master, 800 ns clock, phase 0
  task automatic xfer(input logic [7:0] v, input logic sel);
    ss_n = !sel;
    #400;
    for (int b = 7; b >= 0; b--) begin
      mosi_b = v[b];
      #400;
      sck_b = 1;
      mi[b] = miso_w;
      #400;
      sck_b = 0;
    end
    #400;
    ss_n = 1;
    #400;
  endtask
  task automatic finish_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Look at settled values; the next rising edge takes the word
  always @(negedge clk)
    if (rxv === 1'b1 && rxr === 1'b1)
      chk(rxd, q.size() ? q.pop_front() : ~rxd);
  initial begin
    #1000000;
    n_errors++;
    finish_test;
  end
  initial begin
    seed = 32'h18BAB676;
    {rstn, prst, errclr, txv, rxr, sck_b, mosi_b} = 7'h00;
    ss_n = 1;
    wreq_b = 1;
    cfg = 4'h4;
    req_en = 2'h0;
    txd = 8'h00;
    last = 8'h3C;
    n_errors = 0;
    compares = 0;
    step(4);
    chk({sck_oe, miso_oe, mosi_oe, wreq_oe, wreq}, 8'h01);
    rstn = 1;
    step(2);
    for (int i = 0; i < 3; i++)
      mput;
    txv = 0;
    step(300);
    chk({rxv, txrdy, ovr}, 8'h04);
    rxr = 1;
    drain;
    req_en = 2'h1;
    mput;
    txv = 0;
    step(60);
    chk(8'(q.size()), 8'h01);
    wreq_b = 0;
    drain;
    wreq_b = 1;
    ss_n = 0;
    step(8);
    chk(berr, 1'b1);
    ss_n = 1;
    step(6);
    errclr = 1;
    step(1);
    errclr = 0;
    step(1);
    chk(berr, 1'b0);
    prst = 1;
    step(1);
    chk({sck_oe, miso_oe, mosi_oe, wreq_oe}, 8'h00);
    prst = 0;
    cfg = 4'h0;
    step(6);
    chk(miso_oe, 1'b0);
    xfer(8'h96, 1'b0);
    step(8);
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      send(d);
      txv = 0;
      step(4);
      chk({wreq_oe, wreq}, 8'h02);
      mo = 8'($random(seed));
      q.push_back(mo);
      xfer(mo, 1'b1);
      chk(mi, d);
      step(8);
    end
    chk({ovr, 7'(q.size())}, 8'h00);
    cfg = 4'hC;
    sck_b = 1;
    step(8);
    chk({sck_oe, miso_oe, mosi_oe}, 8'h00);
    finish_test;
  end
endmodule
